/* fov_pkg.sv */
`default_nettype none
package fov_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on the slave bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_WOC = 4'h0;    // wait_overlap_control
  localparam logic [3:0] REG_FPC = 4'h4;    // flash_program_control
  localparam logic [3:0] REG_STAT = 4'h8;   // Status, read only

  // ----------------------------------------------------------------
  // Field positions and values after reset
  // ----------------------------------------------------------------
  localparam int SEL_HI_BIT = 7;            // overlap_select_high
  localparam int SEL_LO_BIT = 6;            // overlap_select_low
  localparam logic [7:0] WOC_RESET = 8'h08; // Only bit 3 set
  localparam int FPC_PROG_BIT = 0;          // Program
  localparam int FPC_ERASE_BIT = 1;         // Erase
  localparam int FPC_PV_BIT = 2;            // Program verify
  localparam int FPC_EV_BIT = 3;            // Erase verify
  localparam logic [3:0] FPC_RESET = 4'h0;
  localparam logic [1:0] SEL_VECTOR = 2'h3; // Both select bits set

  // ----------------------------------------------------------------
  // Address map of the overlay
  // ----------------------------------------------------------------
  localparam logic [15:0] FLASH_LO = 16'h0000;
  localparam logic [15:0] FLASH_HI = 16'h7fff;
  localparam logic [15:0] RAM_LO = 16'hfb80;
  localparam logic [15:0] RAM_HI = 16'hff7f;
  localparam logic [15:0] OVL_OFFSET = 16'hfc00; // Flash to RAM shift
  localparam logic [15:0] WIN01_LO = 16'h0080;
  localparam logic [15:0] WIN01_HI = 16'h00ff;
  localparam logic [15:0] WIN10_LO = 16'h0080;
  localparam logic [15:0] WIN10_HI = 16'h017f;
  localparam logic [15:0] WIN11_LO = 16'h0000;
  localparam logic [15:0] WIN11_HI = 16'h007f;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Declared in select-pair order, so the pair casts straight in
  typedef enum logic [1:0] {
    OVL_NONE,
    OVL_SMALL,
    OVL_WIDE,
    OVL_VECTOR
  } fov_ovl_e;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } fov_bus_e;
endpackage : fov_pkg
`default_nettype wire

/* fov_map_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// Address remap carrier between the top and the decoder
// ------------------------------------------------------------------
interface fov_map_if;
  logic [1:0] sel;         // Overlap select pair, high bit first
  logic [15:0] addr;       // Processor address
  logic ram_hit;           // Access lands in RAM
  logic flash_hit;         // Access lands in flash
  logic [15:0] phys;       // Address after remap
  modport dec (input sel, input addr, output ram_hit, output flash_hit,
    output phys);
  modport use_side (output sel, output addr, input ram_hit,
    input flash_hit, input phys);
endinterface : fov_map_if
`default_nettype wire

/* fov_remap.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// Overlay address decoder, purely combinational
// ------------------------------------------------------------------
module fov_remap (
  fov_map_if.dec m
);
  // Decoder result, one packed struct as elsewhere
  typedef struct packed {
    logic ram_hit;
    logic flash_hit;
    logic [15:0] phys;
  } fov_dec_s;

  fov_dec_s next_dec;  // Filled below
  logic in_win;        // Address inside the selected window

  // Window test per encoding; every window shifts by the same offset
  always_comb begin
    case (fov_pkg::fov_ovl_e'(m.sel))
      fov_pkg::OVL_SMALL: begin
        in_win = m.addr >= fov_pkg::WIN01_LO && m.addr <= fov_pkg::WIN01_HI;
      end
      fov_pkg::OVL_WIDE: begin
        in_win = m.addr >= fov_pkg::WIN10_LO && m.addr <= fov_pkg::WIN10_HI;
      end
      fov_pkg::OVL_VECTOR: begin
        in_win = m.addr <= fov_pkg::WIN11_HI;
      end
      default: begin
        in_win = 1'b0;
      end
    endcase
  end

  // Route the access
  always_comb begin
    next_dec = '0;
    if (in_win) begin
      next_dec.ram_hit = 1'b1;
      next_dec.phys = 16'(m.addr + fov_pkg::OVL_OFFSET);
    end else if (m.addr <= fov_pkg::FLASH_HI) begin
      next_dec.flash_hit = 1'b1;
      next_dec.phys = m.addr;
    end else if (m.addr >= fov_pkg::RAM_LO && m.addr <= fov_pkg::RAM_HI) begin
      next_dec.ram_hit = 1'b1;
      next_dec.phys = m.addr;
    end
  end

  assign m.ram_hit = next_dec.ram_hit;
  assign m.flash_hit = next_dec.flash_hit;
  assign m.phys = next_dec.phys;
endmodule : fov_remap
`default_nettype wire

/* fov_top.sv */
`timescale 1ns/100ps
`default_nettype none
module fov_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic int_mask,
  input wire logic program_voltage_pin,
  input wire logic hw_standby,
  input wire logic boot_exec,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ram_hit,
  output logic mem_flash_hit,
  output logic [15:0] mem_phys,
  output logic mem_read_valid,
  output logic flash_prog_en,
  output logic flash_erase_en,
  output logic flash_verify_en,
  output logic flash_abort,
  output logic irq_gate
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;  // Release shift, first stage read only here
  logic rst_n;           // Synchronised reset used by all below

  // Two stages so the release lands cleanly on the clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] woc;          // wait_overlap_control
    logic [3:0] fpc;          // flash_program_control
    logic int_prot;           // Interrupt protection latched
    logic strap_done;         // Boot strap already sampled
    fov_pkg::fov_bus_e bus;   // Slave handshake phase
    logic wait_n;             // Inverse of waitrequest
    logic [31:0] rdata;       // Read data held for the master
    logic ram_hit;
    logic flash_hit;
    logic [15:0] phys;
    logic read_valid;
    logic prog_en;
    logic erase_en;
    logic verify_en;
    logic abort;
    logic irq_gate;
  } fov_state_s;

  fov_state_s st;        // Registered state
  fov_state_s next_st;   // Next state
  fov_map_if map ();     // Decoder carrier
  logic pe;              // Program or erase requested
  logic emul_prot;       // Exactly one select bit set
  logic take_irq;        // Interrupt accepted this cycle
  logic [31:0] rd_mux;   // Register read value

  fov_remap u_remap (
    .m(map)
  );
  assign map.sel = st.woc[fov_pkg::SEL_HI_BIT:fov_pkg::SEL_LO_BIT];
  assign map.addr = mem_addr;

  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  assign pe = st.fpc[fov_pkg::FPC_PROG_BIT] | st.fpc[fov_pkg::FPC_ERASE_BIT];
  assign emul_prot = st.woc[fov_pkg::SEL_HI_BIT]
    ^ st.woc[fov_pkg::SEL_LO_BIT];
  assign take_irq = nmi_req | (irq_req & ~int_mask & ~boot_exec);

  // Register read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      fov_pkg::REG_WOC: begin
        rd_mux = {24'h0, st.woc};
      end
      fov_pkg::REG_FPC: begin
        rd_mux = {28'h0, st.fpc};
      end
      fov_pkg::REG_STAT: begin
        rd_mux = {27'h0, boot_exec, program_voltage_pin, emul_prot,
          st.abort, st.int_prot};
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.abort = 1'b0;
    // Bus slave: one cycle to answer, write lands at completion
    case (st.bus)
      fov_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.wait_n = 1'b1;
          next_st.rdata = rd_mux;
          next_st.bus = fov_pkg::BUS_ANSWER;
        end
      end
      fov_pkg::BUS_ANSWER: begin
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == fov_pkg::REG_WOC) begin
            next_st.woc = avs_writedata[7:0];
          end else if (avs_address == fov_pkg::REG_FPC) begin
            next_st.fpc = avs_writedata[3:0];
          end
        end
        next_st.wait_n = 1'b0;
        next_st.bus = fov_pkg::BUS_IDLE;
      end
      default: begin
        next_st.wait_n = 1'b0;
        next_st.bus = fov_pkg::BUS_IDLE;
      end
    endcase
    // boot strap sets vector overlay once after release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      if (boot_exec) begin
        next_st.woc[fov_pkg::SEL_HI_BIT] = 1'b1;
        next_st.woc[fov_pkg::SEL_LO_BIT] = 1'b1;
      end
    end
    // abort on interrupt; settings themselves are kept
    // settings kept, protection sticky until reset
    if (pe && take_irq) begin
      next_st.int_prot = 1'b1;
      next_st.abort = 1'b1;
    end
    // Missing programming voltage clears the flash controls
    if (!program_voltage_pin) begin
      next_st.fpc = fov_pkg::FPC_RESET;
    end
    if (hw_standby) begin
      next_st.woc = fov_pkg::WOC_RESET;
      next_st.fpc = fov_pkg::FPC_RESET;
    end
    // enables; an accepted interrupt stops them at once
    next_st.prog_en = st.fpc[fov_pkg::FPC_PROG_BIT] & program_voltage_pin
      & ~st.int_prot & ~emul_prot & ~take_irq & ~hw_standby;
    next_st.erase_en = st.fpc[fov_pkg::FPC_ERASE_BIT] & program_voltage_pin
      & ~st.int_prot & ~emul_prot & ~take_irq & ~hw_standby;
    // Verify survives interrupt and emulation protect
    next_st.verify_en = (st.fpc[fov_pkg::FPC_PV_BIT]
      | st.fpc[fov_pkg::FPC_EV_BIT]) & program_voltage_pin & ~hw_standby;
    next_st.irq_gate = ~boot_exec & ~int_mask;
    // vector fetches follow the decoder; both aliases same cells
    next_st.ram_hit = mem_req & map.ram_hit;
    next_st.flash_hit = mem_req & map.flash_hit;
    next_st.phys = mem_req ? map.phys : 16'h0;
    // flash data unusable while program or erase is set
    next_st.read_valid = mem_req & (map.ram_hit | (map.flash_hit & ~pe));
  end

  // One register for the whole state; protection clears only here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.woc <= fov_pkg::WOC_RESET;
      st.fpc <= fov_pkg::FPC_RESET;
      st.bus <= fov_pkg::BUS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = ~st.wait_n;
  assign mem_ram_hit = st.ram_hit;
  assign mem_flash_hit = st.flash_hit;
  assign mem_phys = st.phys;
  assign mem_read_valid = st.read_valid;
  assign flash_prog_en = st.prog_en;
  assign flash_erase_en = st.erase_en;
  assign flash_verify_en = st.verify_en;
  assign flash_abort = st.abort;
  assign irq_gate = st.irq_gate;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  abort_on_irq_a: assert property (
    pe && take_irq |=> flash_abort && st.int_prot && !flash_prog_en
      && !flash_erase_en)
    else $error("interrupt did not abort program or erase");

  mask_gate_a: assert property (
    int_mask && !nmi_req && !st.int_prot && pe |=> !flash_abort)
    else $error("masked interrupt aborted flash operation");

  flash_read_a: assert property (
    mem_req && pe && map.flash_hit |=> mem_flash_hit && !mem_read_valid)
    else $error("flash read flagged valid during program or erase");

  vector_ovl_a: assert property (
    map.sel == fov_pkg::SEL_VECTOR && mem_req && mem_addr == 16'h0006
      |=> mem_ram_hit && !mem_flash_hit && mem_phys == 16'hfc06)
    else $error("vector fetch not served from RAM");

  outside_win_a: assert property (
    map.sel == 2'h1 && mem_req && mem_addr == 16'h0100
      |=> mem_flash_hit && mem_phys == 16'h0100)
    else $error("address outside window was remapped");

  ram_alias_a: assert property (
    mem_req && mem_addr == 16'hfd00 |=> mem_ram_hit && mem_phys == 16'hfd00)
    else $error("original RAM alias lost");

  standby_init_a: assert property (
    hw_standby |=> st.woc == 8'h08 && st.fpc == 4'h0 && !flash_prog_en)
    else $error("standby did not reinitialise registers");

  emul_block_a: assert property (
    emul_prot |=> !flash_prog_en && !flash_erase_en)
    else $error("program or erase allowed under emulation");

  prot_hold_a: assert property (
    st.int_prot |=> st.int_prot)
    else $error("interrupt protection cleared without reset");

  boot_gate_a: assert property (
    boot_exec |=> !irq_gate)
    else $error("maskable interrupt allowed in boot");

  bus_write_c: cover property (avs_write && !avs_waitrequest);
  abort_c: cover property (flash_abort);
  vector_c: cover property (mem_ram_hit && mem_phys == 16'hfc06);
  emul_c: cover property (emul_prot && st.fpc[fov_pkg::FPC_PROG_BIT]);
endmodule : fov_top
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic arst_n;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic irq_req, nmi_req, int_mask, program_voltage_pin;
  logic hw_standby, boot_exec, mem_req;
  logic [15:0] mem_addr, mem_phys;
  logic mem_ram_hit, mem_flash_hit, mem_read_valid;
  logic flash_prog_en, flash_erase_en, flash_verify_en;
  logic flash_abort, irq_gate;
  int errors, n_compared;
  logic [31:0] rd; // Last read data taken at the completion edge
  // Window edges, neighbours and the untouched spaces
  localparam logic [15:0] PROBES [13] = '{16'h0000, 16'h0006,
    16'h007f, 16'h0080, 16'h00ff, 16'h0100, 16'h017f, 16'h0180,
    16'hfc06, 16'hfc80, 16'hfd7f, 16'h9000, 16'hfd00};

  fov_top i_dut (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .irq_req, .nmi_req, .int_mask, .program_voltage_pin, .hw_standby,
    .boot_exec, .mem_req, .mem_addr, .mem_ram_hit, .mem_flash_hit,
    .mem_phys, .mem_read_valid, .flash_prog_en, .flash_erase_en,
    .flash_verify_en, .flash_abort, .irq_gate);

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Verdict; the only place the run ends
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Case-equal compare, so an unknown never matches
  task check(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Watch waitrequest between edges; the rising edge after it is seen
  // low completes the transfer, takes the data and releases
  task wait_ack();
    int i;
    i = 0;
    @(negedge sys_clk);
    while (avs_waitrequest !== 1'b0 && i < 20) begin
      @(negedge sys_clk);
      i++;
    end
    if (avs_waitrequest === 1'b0) begin
      @(posedge sys_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end else begin
      errors++;
      $display("ERROR %0t: bus answer missing", $time);
      conclude();
    end
  endtask : wait_ack

  task bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= 1'b1;
    wait_ack();
  endtask : bus_write

  task bus_read(input logic [3:0] a);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
  endtask : bus_read

  // One processor access; the answer stands in the following cycle
  task mem_probe(input logic [15:0] a, input logic rh, input logic fh,
    input logic [15:0] ph);
    @(posedge sys_clk);
    mem_req <= 1'b1;
    mem_addr <= a;
    @(posedge sys_clk);
    mem_req <= 1'b0;
    @(negedge sys_clk);
    check({31'h0, mem_ram_hit}, {31'h0, rh}, "ram hit");
    check({31'h0, mem_flash_hit}, {31'h0, fh}, "flash hit");
    check({16'h0, mem_phys}, {16'h0, ph}, "phys");
  endtask : mem_probe

  // Reset held 16 cycles; boot strap level set before release
  task do_reset(input logic b);
    arst_n <= 1'b0;
    boot_exec <= b;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs();
    bus_read(4'h0);
    check(rd, 32'h08, "woc reset");
    bus_write(4'h0, 8'hf7);
    bus_read(4'h0);
    check(rd, 32'hf7, "woc rw");
    avs_byteenable <= 4'h0;
    bus_write(4'h0, 8'h55);
    avs_byteenable <= 4'hf;
    bus_read(4'h0);
    check(rd, 32'hf7, "lane off write");
    bus_read(4'hc);
    check(rd, 32'h0, "unmapped read");
    @(posedge sys_clk);
    hw_standby <= 1'b1;
    @(posedge sys_clk);
    hw_standby <= 1'b0;
    bus_read(4'h0);
    check(rd, 32'h08, "woc after standby");
    $display("t_regs done");
  endtask : t_regs

  // Every select code against every probe address
  task t_remap();
    logic [15:0] a, lo, hi;
    for (int s = 0; s < 4; s++) begin
      bus_write(4'h0, {s[1:0], 6'h08});
      lo = (s == 3) ? 16'h0000 : 16'h0080;
      hi = (s == 1) ? 16'h00ff : (s == 2) ? 16'h017f : 16'h007f;
      if (s == 0) lo = 16'hffff;
      for (int k = 0; k < 13; k++) begin
        a = PROBES[k];
        if (a >= lo && a <= hi) begin
          mem_probe(a, 1'b1, 1'b0, a + 16'hfc00);
        end else if (a <= 16'h7fff) begin
          mem_probe(a, 1'b0, 1'b1, a);
        end else if (a >= 16'hfb80 && a <= 16'hff7f) begin
          mem_probe(a, 1'b1, 1'b0, a);
        end else begin
          mem_probe(a, 1'b0, 1'b0, 16'h0000);
        end
      end
    end
    $display("t_remap done");
  endtask : t_remap

  // One select bit alone blocks program and erase, verify survives
  task t_emul();
    @(posedge sys_clk);
    program_voltage_pin <= 1'b1;
    bus_write(4'h0, 8'h48);
    // watchdog assumed running while erase set
    bus_write(4'h4, 8'h02);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, flash_erase_en}, 32'h0, "erase sel 01");
    bus_write(4'h0, 8'hc8);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, flash_erase_en}, 32'h1, "erase sel 11");
    bus_write(4'h0, 8'h48);
    bus_write(4'h4, 8'h05);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, flash_prog_en}, 32'h0, "prog sel 01");
    check({31'h0, flash_verify_en}, 32'h1, "verify sel 01");
    bus_write(4'h0, 8'h88);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, flash_prog_en}, 32'h0, "prog sel 10");
    // vector in RAM before both bits
    bus_write(4'h0, 8'hc8);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, flash_prog_en}, 32'h1, "prog sel 11");
    mem_probe(16'h0006, 1'b1, 1'b0, 16'hfc06);
    check({31'h0, mem_read_valid}, 32'h1, "RAM read valid");
    mem_probe(16'h0200, 1'b0, 1'b1, 16'h0200);
    check({31'h0, mem_read_valid}, 32'h0, "flash read in program");
    $display("t_emul done");
  endtask : t_emul

  // Masked interrupt is ignored, the non-maskable one aborts
  task t_abort();
    @(posedge sys_clk);
    int_mask <= 1'b1;
    irq_req <= 1'b1;
    repeat (3) begin
      @(negedge sys_clk);
      check({31'h0, flash_abort}, 32'h0, "masked abort");
    end
    check({31'h0, flash_prog_en}, 32'h1, "masked prog");
    @(posedge sys_clk);
    nmi_req <= 1'b1;
    @(posedge sys_clk);
    nmi_req <= 1'b0;
    @(negedge sys_clk);
    check({31'h0, flash_abort}, 32'h1, "abort pulse");
    check({31'h0, flash_prog_en}, 32'h0, "prog after abort");
    @(negedge sys_clk);
    check({31'h0, flash_abort}, 32'h0, "abort one cycle");
    @(posedge sys_clk);
    irq_req <= 1'b0;
    bus_read(4'h8);
    check(rd & 32'h1, 32'h1, "protect flag");
    bus_read(4'h4);
    check(rd, 32'h05, "fpc kept");
    check({31'h0, flash_prog_en}, 32'h0, "prog still off");
    int_mask <= 1'b0;
    $display("t_abort done");
  endtask : t_abort

  // Boot strap sets the vector overlay and shuts maskable interrupts
  task t_boot();
    // vector image assumed left in RAM
    bus_read(4'h0);
    check(rd, 32'hc8, "boot woc");
    check({31'h0, irq_gate}, 32'h0, "boot irq gate");
    boot_exec <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, irq_gate}, 32'h1, "irq gate open");
    bus_write(4'h0, 8'h08);
    mem_probe(16'h0006, 1'b0, 1'b1, 16'h0006);
    check({31'h0, mem_read_valid}, 32'h1, "flash read idle");
    $display("t_boot done");
  endtask : t_boot

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {irq_req, nmi_req, int_mask, program_voltage_pin} = 4'h0;
    {hw_standby, boot_exec, mem_req, mem_addr} = '0;
    errors = 0;
    n_compared = 0;
    do_reset(1'b0);
    t_regs();
    t_remap();
    t_emul();
    t_abort();
    do_reset(1'b1);
    t_boot();
    conclude();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    $display("ERROR %0t: run limit reached", $time);
    conclude();
  end
endmodule : testbench
`default_nettype wire
